// file: include/appc_pkg.sv
// Constants shared by the audio post-processing command decoder files.
// Assumes 8-bit host port data and a 5-bit host register address.
package appc_pkg;
  // ----------------------------------------------------------------
  // Host port register addresses
  // ----------------------------------------------------------------
  localparam logic [4:0] ADDR_COMMAND = 5'h00;
  localparam logic [4:0] ADDR_PARAM = 5'h02;
  localparam logic [4:0] ADDR_DEC_STATUS = 5'h11;
  localparam logic [4:0] ADDR_FRAME_HDR = 5'h1B;
  localparam logic [4:0] ADDR_BOOST_RPT = 5'h1D;
  // ----------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_BASS_BOOST = 8'h20;
  localparam logic [7:0] CMD_VOLUME = 8'h21;
  localparam logic [7:0] CMD_PRESCALE = 8'h22;
  localparam logic [7:0] CMD_BASS_GAIN = 8'h23;
  localparam logic [7:0] CMD_TREBLE_GAIN = 8'h24;
  localparam logic [7:0] CMD_BASS_CUT = 8'h25;
  localparam logic [7:0] CMD_TREBLE_CUT = 8'h26;
  localparam logic [7:0] CMD_TONE_ON = 8'h27;
  localparam logic [7:0] CMD_TONE_OFF = 8'h28;
  localparam logic [7:0] CMD_CRC_BYPASS = 8'h30;
  localparam logic [7:0] CMD_CRC_CHECK = 8'h31;
  localparam logic [7:0] CMD_EQ_BAND1 = 8'h40;
  localparam logic [7:0] CMD_EQ_BAND6 = 8'h45;
  localparam logic [7:0] CMD_EQ_ON = 8'h46;
  localparam logic [7:0] CMD_EQ_OFF = 8'h47;
  localparam logic [4:0] CMD_DAC_FMT_HI = 5'h10;
  // ----------------------------------------------------------------
  // Field positions and limits
  // ----------------------------------------------------------------
  localparam int DAC_I2S_BIT = 2;
  localparam int DAC_PL_BIT = 1;
  localparam int DAC_PB_BIT = 0;
  localparam logic [3:0] BOOST_CUT_MAX = 4'h6;
  localparam logic [3:0] BOOST_LVL_MAX = 4'hC;
  localparam logic [7:0] BOOST_CUT_OFS = 8'h06;
  // ----------------------------------------------------------------
  // Reset and forced values (gains in half-dB steps)
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_BOOST = 8'hFF;
  localparam logic [7:0] RST_SETTING = 8'h00;
  localparam logic [7:0] BOOST_PRESCALE = 8'hE8;
  localparam logic [7:0] BOOST_TREBLE = 8'h00;
  localparam int EQ_BANDS = 6;
  // ----------------------------------------------------------------
  // Command engine states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_EXEC = 2'b10
  } appc_state_t;
endpackage : appc_pkg

// file: src/appc_boost_map.sv
// Bass boost parameter decoder: nibbles to tone filter settings.
// Assumes the caller registers the outputs.
`timescale 1ns/10ps
module appc_boost_map
  import appc_pkg::*;
(
  // Parameter byte
  input wire logic [7:0] param,
  // Decoded settings
  output logic valid,
  output logic [7:0] gain,
  output logic [7:0] cutoff
);
  logic [3:0] cut_sel;
  logic [3:0] lvl_sel;

  assign cut_sel = param[7:4];
  assign lvl_sel = param[3:0];
  // Level above 12 means no boost
  assign valid = (cut_sel <= BOOST_CUT_MAX) && (lvl_sel <= BOOST_LVL_MAX);
  // 1.5 dB per step is three half-dB units
  assign gain = {3'h0, lvl_sel, 1'b0} + {4'h0, lvl_sel};
  // 25u+50 Hz expressed as a 20+5n cutoff code: n = 5u+6
  assign cutoff = {2'h0, cut_sel, 2'h0} + {4'h0, cut_sel} + BOOST_CUT_OFS;
endmodule : appc_boost_map

// file: src/appc_eq_mem.sv
// Equalizer band gain store with registered read data.
// Assumes a single writer; all entries reset to 0 dB.
`timescale 1ns/10ps
module appc_eq_mem #(
  parameter int DW = 8,
  parameter int DEPTH = 6,
  parameter int AW = 3
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Write port
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_idx,
  input wire logic [DW-1:0] wr_data,
  // Read port
  input wire logic [AW-1:0] rd_idx,
  output logic [DW-1:0] rd_data_r
);
  logic [DW-1:0] mem_r [DEPTH];

  genvar g;
  generate
    for (g = 0; g < DEPTH; g++)
    begin : g_entry
      always_ff @(posedge clk or posedge rst)
      begin
        if (rst)
          mem_r[g] <= '0;
        else if (wr_en && (wr_idx == AW'(g)))
          mem_r[g] <= wr_data;
      end
    end
  endgenerate

  // Out-of-range index reads zero
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      rd_data_r <= '0;
    else if (rd_idx < AW'(DEPTH))
      rd_data_r <= mem_r[rd_idx];
    else
      rd_data_r <= '0;
  end
endmodule : appc_eq_mem

// file: src/appc_decoder.sv
// Host command decoder for audio post-processing settings.
// Assumes host strobes are synchronous one-cycle pulses on clk.
`timescale 1ns/10ps
module appc_decoder
  import appc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Host register port
  input wire logic hip_wr,
  input wire logic hip_rd,
  input wire logic [4:0] hip_addr,
  input wire logic [7:0] hip_wdata,
  output logic [7:0] hip_rdata,
  // Decoder core status
  input wire logic deemph_enable,
  input wire logic mute_off_flag,
  input wire logic [1:0] sample_rate_code,
  // Frame header from the stream parser
  input wire logic hdr_valid,
  input wire logic [1:0] chan_mode,
  input wire logic [1:0] joint_coding_method,
  input wire logic copyright_flag,
  input wire logic original_flag,
  input wire logic [1:0] deemph_type,
  // Frame CRC result, sampled at frame start
  input wire logic frame_start,
  input wire logic frame_crc_fail,
  // Filter settings
  output logic [7:0] volume,
  output logic [7:0] prescale,
  output logic prescale_active,
  output logic [7:0] bass_gain,
  output logic [7:0] treble_gain,
  output logic [7:0] bass_cutoff,
  output logic [7:0] treble_cutoff,
  output logic tone_enable,
  output logic crc_check,
  output logic frame_zero,
  // Equalizer
  output logic eq_enable,
  output logic eq_recompute,
  input wire logic [2:0] eq_rd_band,
  output logic [7:0] eq_rd_gain,
  // DAC format
  output logic dac_i2s,
  output logic polarity_l,
  output logic polarity_b
);
  // ----------------------------------------------------------------
  // Command capture
  // ----------------------------------------------------------------
  appc_state_t state_r;
  logic [7:0] cmd_r;
  logic [7:0] param_r;
  logic [7:0] bass_boost_report_r;
  logic boost_seen_r;
  logic [7:0] decoder_status_r;
  logic [7:0] frame_header_status_r;
  logic cmd_wr;
  logic exec;
  logic is_band;
  logic is_dac_fmt;
  logic boost_valid;
  logic [7:0] boost_gain;
  logic [7:0] boost_cut;

  assign cmd_wr = hip_wr && (hip_addr == ADDR_COMMAND);
  assign exec = (state_r == ST_EXEC);
  assign is_band = (cmd_r >= CMD_EQ_BAND1) && (cmd_r <= CMD_EQ_BAND6);
  assign is_dac_fmt = (cmd_r[7:3] == CMD_DAC_FMT_HI);

  // Parameter bytes only land in a holding register
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      param_r <= RST_SETTING;
    else if (hip_wr && (hip_addr == ADDR_PARAM))
      param_r <= hip_wdata;
  end

  // Only a command write starts execution
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_r <= ST_IDLE;
      cmd_r <= RST_SETTING;
    end
    else
    begin
      case (state_r)
        ST_IDLE:
          if (cmd_wr)
            state_r <= ST_EXEC;
        ST_EXEC:
          if (!cmd_wr)
            state_r <= ST_IDLE;
        default:
          state_r <= ST_IDLE;
      endcase
      if (cmd_wr)
        cmd_r <= hip_wdata;
    end
  end

  appc_boost_map u_boost_map (
    .param(param_r),
    .valid(boost_valid),
    .gain(boost_gain),
    .cutoff(boost_cut)
  );

  // ----------------------------------------------------------------
  // Tone control settings
  // ----------------------------------------------------------------
  // Codes not matched below fall through and leave settings alone
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      volume <= RST_SETTING;
      prescale <= RST_SETTING;
      bass_gain <= RST_SETTING;
      treble_gain <= RST_SETTING;
      bass_cutoff <= RST_SETTING;
      treble_cutoff <= RST_SETTING;
      tone_enable <= 1'b0;
      bass_boost_report_r <= RST_BOOST;
      boost_seen_r <= 1'b0;
    end
    else if (exec)
    begin
      case (cmd_r)
        CMD_BASS_BOOST:
        begin
          boost_seen_r <= 1'b1;
          if (boost_valid)
          begin
            bass_gain <= boost_gain;
            bass_cutoff <= boost_cut;
            treble_gain <= BOOST_TREBLE;
            prescale <= BOOST_PRESCALE;
            tone_enable <= 1'b1;
            bass_boost_report_r <= param_r;
          end
          else
          begin
            tone_enable <= 1'b0;
            bass_boost_report_r <= RST_BOOST;
          end
        end
        CMD_VOLUME:
          volume <= param_r;
        CMD_PRESCALE:
          prescale <= param_r;
        CMD_BASS_GAIN:
          bass_gain <= param_r;
        CMD_TREBLE_GAIN:
          treble_gain <= param_r;
        CMD_BASS_CUT:
          bass_cutoff <= param_r;
        CMD_TREBLE_CUT:
          treble_cutoff <= param_r;
        CMD_TONE_ON:
          tone_enable <= 1'b1;
        CMD_TONE_OFF:
        begin
          tone_enable <= 1'b0;
          bass_boost_report_r <= RST_BOOST;
        end
        default:
          boost_seen_r <= boost_seen_r;
      endcase
    end
  end

  // Prescale is flagged active while tone or EQ is on, and from the first bass boost command until reset
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      prescale_active <= 1'b0;
    else
      prescale_active <= tone_enable || eq_enable || boost_seen_r;
  end

  // ----------------------------------------------------------------
  // CRC policy and frame blanking
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      crc_check <= 1'b1;
    else if (exec && (cmd_r == CMD_CRC_BYPASS))
      crc_check <= 1'b0;
    else if (exec && (cmd_r == CMD_CRC_CHECK))
      crc_check <= 1'b1;
  end

  // Blanking holds for the whole frame until the next frame start
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      frame_zero <= 1'b0;
    else if (frame_start)
      frame_zero <= crc_check && frame_crc_fail;
  end

  // ----------------------------------------------------------------
  // Equalizer
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      eq_enable <= 1'b0;
    else if (exec && (cmd_r == CMD_EQ_ON))
      eq_enable <= 1'b1;
    else if (exec && (cmd_r == CMD_EQ_OFF))
      eq_enable <= 1'b0;
  end

  // One-cycle request to rebuild the correction matrix
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      eq_recompute <= 1'b0;
    else
      eq_recompute <= exec && is_band;
  end

  appc_eq_mem #(
    .DW(8),
    .DEPTH(EQ_BANDS),
    .AW(3)
  ) u_eq_mem (
    .clk(clk),
    .rst(rst),
    .wr_en(exec && is_band),
    .wr_idx(cmd_r[2:0]),
    .wr_data(param_r),
    .rd_idx(eq_rd_band),
    .rd_data_r(eq_rd_gain)
  );

  // ----------------------------------------------------------------
  // DAC format
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      dac_i2s <= 1'b0;
      polarity_l <= 1'b0;
      polarity_b <= 1'b0;
    end
    else if (exec && is_dac_fmt)
    begin
      dac_i2s <= cmd_r[DAC_I2S_BIT];
      polarity_l <= cmd_r[DAC_PL_BIT];
      polarity_b <= cmd_r[DAC_PB_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Status bytes and host read
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      decoder_status_r <= RST_SETTING;
    else
      decoder_status_r <= {4'h0, deemph_enable, mute_off_flag,
                           sample_rate_code};
  end

  // Header byte tracks the most recently synchronised frame
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      frame_header_status_r <= RST_SETTING;
    else if (hdr_valid)
      frame_header_status_r <= {chan_mode, joint_coding_method,
                                copyright_flag, original_flag,
                                deemph_type};
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      hip_rdata <= RST_SETTING;
    else if (hip_rd)
    begin
      case (hip_addr)
        ADDR_DEC_STATUS:
          hip_rdata <= decoder_status_r;
        ADDR_FRAME_HDR:
          hip_rdata <= frame_header_status_r;
        ADDR_BOOST_RPT:
          hip_rdata <= bass_boost_report_r;
        default:
          hip_rdata <= RST_SETTING;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_boost_valid;
    @(posedge clk) disable iff (rst)
    exec && (cmd_r == CMD_BASS_BOOST) && boost_valid |=>
      (treble_gain == BOOST_TREBLE) && (prescale == BOOST_PRESCALE)
      && tone_enable && (bass_gain == $past(boost_gain));
  endproperty
  a_boost_valid: assert property (p_boost_valid)
    else $error("valid boost did not set tone path");

  property p_boost_bad;
    @(posedge clk) disable iff (rst)
    exec && (cmd_r == CMD_BASS_BOOST) && !boost_valid |=>
      !tone_enable && $stable(bass_gain) && $stable(bass_cutoff)
      && $stable(prescale);
  endproperty
  a_boost_bad: assert property (p_boost_bad)
    else $error("invalid boost changed a setting");

  property p_tone_off;
    @(posedge clk) disable iff (rst)
    exec && (cmd_r == CMD_TONE_OFF) |=>
      (bass_boost_report_r == RST_BOOST) && !tone_enable;
  endproperty
  a_tone_off: assert property (p_tone_off)
    else $error("tone disable left boost report set");

  property p_gain_only;
    @(posedge clk) disable iff (rst)
    exec && (cmd_r == CMD_BASS_GAIN) |=>
      $stable(tone_enable) && $stable(prescale)
      && $stable(bass_boost_report_r);
  endproperty
  a_gain_only: assert property (p_gain_only)
    else $error("bass gain command touched other state");

  property p_param_only;
    @(posedge clk) disable iff (rst)
    hip_wr && (hip_addr == ADDR_PARAM) && !exec && !cmd_wr |=>
      $stable(volume) ##1 $stable(volume);
  endproperty
  a_param_only: assert property (p_param_only)
    else $error("parameter write alone changed volume");

  property p_pre_act;
    @(posedge clk) disable iff (rst)
    $rose(eq_enable) |=> prescale_active;
  endproperty
  a_pre_act: assert property (p_pre_act)
    else $error("prescale inactive with equalizer on");

  property p_recompute;
    @(posedge clk) disable iff (rst)
    cmd_wr && (hip_wdata >= CMD_EQ_BAND1) && (hip_wdata <= CMD_EQ_BAND6)
      |=> ##1 eq_recompute;
  endproperty
  a_recompute: assert property (p_recompute)
    else $error("band gain write gave no recompute");

  property p_bypass;
    @(posedge clk) disable iff (rst)
    !crc_check && frame_start |=> !frame_zero;
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("frame blanked with CRC bypassed");

  property p_undef;
    @(posedge clk) disable iff (rst)
    exec && (cmd_r == 8'h50) |=>
      $stable(volume) && $stable(tone_enable) && $stable(eq_enable);
  endproperty
  a_undef: assert property (p_undef)
    else $error("undefined command changed a setting");
endmodule : appc_decoder

// file: test/appc_host_model.sv
// Host microcontroller model for the command decoder register port.
// Assumes one bench process calls its tasks, each starting on a clock edge.
`timescale 1ns/10ps
module appc_host_model
  import appc_pkg::*;
(
  // Clock
  input wire logic clk,
  // Host register port
  output logic hip_wr,
  output logic hip_rd,
  output logic [4:0] hip_addr,
  output logic [7:0] hip_wdata
);
  initial
  begin
    hip_wr = 1'b0;
    hip_rd = 1'b0;
    hip_addr = 5'h1F;
    hip_wdata = 8'h00;
  end

  // Released bus shows the inverse of its last value, never a held copy
  task automatic idle;
    @(posedge clk);
    hip_wr <= 1'b0;
    hip_rd <= 1'b0;
    hip_addr <= ~hip_addr;
    hip_wdata <= ~hip_wdata;
  endtask : idle

  task automatic put(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    hip_wr <= 1'b1;
    hip_addr <= a;
    hip_wdata <= d;
  endtask : put

  // Parameter first, so the command write finds it in place
  task automatic cmd(input logic [7:0] c, input logic [7:0] p);
    put(ADDR_PARAM, p);
    put(ADDR_COMMAND, c);
    idle();
  endtask : cmd

  task automatic rd(input logic [4:0] a);
    @(posedge clk);
    hip_rd <= 1'b1;
    hip_addr <= a;
    idle();
  endtask : rd
endmodule : appc_host_model

// file: test/tb_top.sv
// Self-checking bench for the audio post-processing command decoder.
// Assumes the host model owns the register port; the bench drives the rest.
`timescale 1ns/10ps
module tb_top
  import appc_pkg::*;
;
  typedef struct {logic [7:0] exp; int src;} appc_note_t;
  logic clk, rst, hip_wr, hip_rd, hdr_valid, frame_start, frame_crc_fail;
  logic deemph_enable, mute_off_flag, copyright_flag, original_flag;
  logic [4:0] hip_addr;
  logic [7:0] hip_wdata, hip_rdata, eq_rd_gain, m_c, m_p;
  logic [1:0] sample_rate_code, chan_mode, joint_coding_method, deemph_type;
  logic [7:0] volume, prescale, bass_gain, treble_gain, bass_cutoff;
  logic [7:0] treble_cutoff;
  logic prescale_active, tone_enable, crc_check, frame_zero, eq_enable;
  logic eq_recompute, dac_i2s, polarity_l, polarity_b, probe, rd_d;
  logic [2:0] eq_rd_band;
  int err_total, compares, recomp_n, m_recomp;
  appc_note_t notes[$];
  appc_note_t nt;
  logic [7:0] m_vol, m_pre, m_bg, m_tg, m_bc, m_tc, m_rpt;
  logic [7:0] m_eqg [6];
  logic m_tone, m_eq, m_crc, m_fz, m_seen, m_i2s, m_pl, m_pb;
  logic [7:0] codes [27] = '{8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25,
    8'h26, 8'h27, 8'h28, 8'h30, 8'h31, 8'h40, 8'h41, 8'h42, 8'h43, 8'h44,
    8'h45, 8'h46, 8'h47, 8'h80, 8'h83, 8'h84, 8'h87, 8'h16, 8'h29, 8'h48,
    8'h88};

  appc_decoder dut (.clk, .rst, .hip_wr, .hip_rd, .hip_addr, .hip_wdata,
    .hip_rdata, .deemph_enable, .mute_off_flag, .sample_rate_code,
    .hdr_valid, .chan_mode, .joint_coding_method, .copyright_flag,
    .original_flag, .deemph_type, .frame_start, .frame_crc_fail, .volume,
    .prescale, .prescale_active, .bass_gain, .treble_gain, .bass_cutoff,
    .treble_cutoff, .tone_enable, .crc_check, .frame_zero, .eq_enable,
    .eq_recompute, .eq_rd_band, .eq_rd_gain, .dac_i2s, .polarity_l,
    .polarity_b);
  appc_host_model host (.clk, .hip_wr, .hip_rd, .hip_addr, .hip_wdata);

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Result checking
  // ----------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      err_total++;
      $display("CHECK FAILED %0t: got %h, expected %h", $time, seen, exp);
    end
  endtask : check

  function automatic logic [7:0] pick(input int s);
    case (s)
      1: return volume;
      2: return prescale;
      3: return bass_gain;
      4: return treble_gain;
      5: return bass_cutoff;
      6: return treble_cutoff;
      7: return {tone_enable, eq_enable, crc_check, frame_zero,
        prescale_active, dac_i2s, polarity_l, polarity_b};
      8: return eq_rd_gain;
      default: return 8'h00;
    endcase
  endfunction : pick

  // Oldest note pairs with the read answer or the probed output
  always @(posedge clk)
  begin
    rd_d <= hip_rd;
    if (rd_d === 1'b1 || probe === 1'b1)
    begin
      nt = notes.pop_front();
      check(nt.src == 0 ? hip_rdata : pick(nt.src), nt.exp);
    end
  end

  always @(posedge clk)
    if (!rst && eq_recompute === 1'b1)
      recomp_n <= recomp_n + 1;

  task automatic print_verdict;
    if (err_total == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : print_verdict

  initial
  begin
    repeat (30000) @(posedge clk);
    err_total++;
    print_verdict();
  end

  // ----------------------------------------------------------------
  // Stimulus and expected-state model
  // ----------------------------------------------------------------
  task automatic note(input int s, input logic [7:0] e);
    notes.push_back('{e, s});
    @(posedge clk);
    probe <= 1'b1;
    @(posedge clk);
    probe <= 1'b0;
  endtask : note

  task automatic expect_rd(input logic [4:0] a, input logic [7:0] e);
    notes.push_back('{e, 0});
    host.rd(a);
  endtask : expect_rd

  task automatic verify;
    logic [7:0] fl;
    fl = {m_tone, m_eq, m_crc, m_fz, m_tone | m_eq | m_seen, m_i2s, m_pl,
      m_pb};
    note(1, m_vol);
    note(2, m_pre);
    note(3, m_bg);
    note(4, m_tg);
    note(5, m_bc);
    note(6, m_tc);
    note(7, fl);
    expect_rd(ADDR_BOOST_RPT, m_rpt);
  endtask : verify

  task automatic do_reset;
    @(posedge clk);
    rst <= 1'b1;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    {m_vol, m_pre, m_bg, m_tg, m_bc, m_tc} = '0;
    m_eqg = '{default: 8'h00};
    {m_tone, m_eq, m_fz, m_seen, m_i2s, m_pl, m_pb} = '0;
    m_crc = 1'b1;
    m_rpt = 8'hFF;
  endtask : do_reset

  task automatic apply(input logic [7:0] c, input logic [7:0] p);
    host.cmd(c, p);
    case (c)
      CMD_BASS_BOOST:
      begin
        m_seen = 1'b1;
        if (p[7:4] <= 4'h6 && p[3:0] <= 4'hC)
        begin
          m_bg = 8'(3 * p[3:0]);
          m_bc = 8'(5 * p[7:4] + 6);
          m_tg = 8'h00;
          m_pre = 8'hE8;
          m_tone = 1'b1;
          m_rpt = p;
        end
        else
        begin
          m_tone = 1'b0;
          m_rpt = 8'hFF;
        end
      end
      CMD_VOLUME: m_vol = p;
      CMD_PRESCALE: m_pre = p;
      CMD_BASS_GAIN: m_bg = p;
      CMD_TREBLE_GAIN: m_tg = p;
      CMD_BASS_CUT: m_bc = p;
      CMD_TREBLE_CUT: m_tc = p;
      CMD_TONE_ON: m_tone = 1'b1;
      CMD_TONE_OFF:
      begin
        m_tone = 1'b0;
        m_rpt = 8'hFF;
      end
      CMD_CRC_BYPASS: m_crc = 1'b0;
      CMD_CRC_CHECK: m_crc = 1'b1;
      CMD_EQ_ON: m_eq = 1'b1;
      CMD_EQ_OFF: m_eq = 1'b0;
      default:
        if (c >= 8'h40 && c <= 8'h45)
        begin
          m_eqg[c[2:0]] = p;
          m_recomp++;
        end
        else if (c[7:3] == 5'h10)
          {m_i2s, m_pl, m_pb} = c[2:0];
    endcase
  endtask : apply

  task automatic eqchk;
    for (int i = 0; i < 7; i++)
    begin
      @(posedge clk);
      eq_rd_band <= 3'(i);
      note(8, i < 6 ? m_eqg[i] : 8'h00);
    end
  endtask : eqchk

  task automatic frame(input logic f);
    @(posedge clk);
    frame_start <= 1'b1;
    frame_crc_fail <= f;
    @(posedge clk);
    frame_start <= 1'b0;
    frame_crc_fail <= ~f;
    m_fz = f & m_crc;
  endtask : frame

  task automatic status;
    logic [7:0] hv;
    hv = 8'($urandom);
    @(posedge clk);
    {deemph_enable, mute_off_flag, sample_rate_code} <= 4'($urandom);
    {chan_mode, joint_coding_method, copyright_flag, original_flag,
      deemph_type} <= hv;
    hdr_valid <= 1'b1;
    @(posedge clk);
    hdr_valid <= 1'b0;
    {chan_mode, joint_coding_method, copyright_flag, original_flag,
      deemph_type} <= ~hv;
    repeat (2) @(posedge clk);
    expect_rd(ADDR_DEC_STATUS, {4'h0, deemph_enable, mute_off_flag,
      sample_rate_code});
    expect_rd(ADDR_FRAME_HDR, hv);
  endtask : status

  initial
  begin
    rst = 1'b1;
    {hdr_valid, frame_start, frame_crc_fail, probe} = '0;
    {deemph_enable, mute_off_flag, sample_rate_code} = '0;
    {chan_mode, joint_coding_method, copyright_flag, original_flag} = '0;
    deemph_type = 2'b00;
    eq_rd_band = 3'h0;
    {err_total, compares, m_recomp} = '0;
    void'($urandom(42));
    do_reset();
    verify();
    eqchk();
    expect_rd(ADDR_DEC_STATUS, 8'h00);
    expect_rd(5'h05, 8'h00);
    apply(CMD_BASS_BOOST, 8'h42);
    verify();
    apply(CMD_BASS_BOOST, 8'h6C);
    apply(CMD_TREBLE_CUT, 8'hFF);
    apply(CMD_BASS_GAIN, 8'h80);
    verify();
    apply(CMD_BASS_BOOST, 8'h7C);
    verify();
    apply(CMD_TONE_ON, 8'h00);
    apply(CMD_BASS_BOOST, 8'h5D);
    verify();
    apply(CMD_TONE_ON, 8'h00);
    apply(CMD_TONE_OFF, 8'h00);
    apply(CMD_PRESCALE, 8'h80);
    apply(CMD_VOLUME, 8'hFF);
    host.put(ADDR_PARAM, 8'h33);
    host.idle();
    verify();
    host.put(ADDR_COMMAND, CMD_EQ_ON);
    host.put(ADDR_COMMAND, CMD_EQ_OFF);
    host.put(ADDR_COMMAND, CMD_EQ_ON);
    host.idle();
    m_eq = 1'b1;
    frame(1'b1);
    verify();
    apply(CMD_CRC_BYPASS, 8'h00);
    frame(1'b1);
    verify();
    for (int i = 0; i < 8; i++)
    begin
      apply(8'h80 | 8'(i), 8'h00);
      verify();
    end
    // An undefined code must leave every stored setting alone
    apply(8'h50, 8'hA5);
    verify();
    for (int k = 0; k < 40; k++)
    begin
      m_c = codes[$urandom_range(0, 26)];
      m_p = 8'($urandom);
      if (m_c >= 8'h40 && m_c <= 8'h45)
        m_p = 8'($urandom_range(0, 20) - 10);
      apply(m_c, m_p);
      if (k % 5 == 4)
        frame(1'($urandom));
      verify();
    end
    eqchk();
    status();
    status();
    check(8'(recomp_n), 8'(m_recomp));
    do_reset();
    verify();
    print_verdict();
  end
endmodule : tb_top
